//--- core/cogc_device.sv
// Clock output group controller: serial register file, dividers, delays and driver control.
`timescale 1ns/1ps
module cogc_device (
   input wire logic mclk,
   input wire logic rstn,
   cogc_if.dev link,
   input wire logic [cogc_pkg::NUM_GROUPS-1:0] group_sync_exclude,
   output logic [cogc_pkg::NUM_GROUPS-1:0][1:0] group_phase,
   output logic [cogc_pkg::NUM_GROUPS-1:0] group_powered,
   output logic [cogc_pkg::NUM_GROUPS-1:0] group_source_select,
   output logic [cogc_pkg::NUM_GROUPS-1:0] analog_block_on,
   output logic [cogc_pkg::NUM_OUTS-1:0] analog_delay_en,
   output logic [cogc_pkg::NUM_GROUPS-1:0] extended_power,
   output logic [cogc_pkg::NUM_OUTS-1:0][3:0] output_driver_type,
   output logic [cogc_pkg::NUM_OUTS-1:0] output_buffer_on,
   output logic [cogc_pkg::NUM_OUTS-1:0][1:0] out_p_phase,
   output logic [cogc_pkg::NUM_OUTS-1:0][1:0] out_n_phase,
   output logic device_power_down,
   output logic soft_reset_flag,
   output logic sync_event
);
   import cogc_pkg::*;

   cogc_dev_state_t s;
   cogc_dev_state_t nx;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0] r;
      logic [11:0] n2;
      logic [11:0] a;
      logic [11:0] b;
      logic [11:0] nxt;
      logic [10:0] dv;
      logic [9:0] eff;
      logic [4:0] addr;
      logic sclk_rise;
      logic le_rise;
      logic le_fall;
      logic wr;
      logic sync;
      logic dev_pd;
      logic pd;
      r = '0;
      n2 = '0;
      a = '0;
      b = '0;
      nxt = '0;
      dv = '0;
      eff = '0;
      addr = '0;
      wr = 1'b0;
      sync = 1'b0;
      pd = 1'b0;
      nx = s;

      // Pins cross into mclk; stage 0 feeds stage 1 only
      nx.sclk_s = {s.sclk_s[1:0], link.sclk};
      nx.data_s = {s.data_s[1:0], link.sdata};
      nx.le_s = {s.le_s[1:0], link.le};
      sclk_rise = s.sclk_s[1] & ~s.sclk_s[2];
      le_rise = s.le_s[1] & ~s.le_s[2];
      le_fall = ~s.le_s[1] & s.le_s[2];
      dev_pd = s.regs[REG_POWERDOWN][POWERDOWN_BIT];

      if (sclk_rise && !s.le_s[1]) begin
         nx.shift = {s.shift[30:0], s.data_s[1]};
         if (s.nbits != NBITS_SAT) begin
            nx.nbits = s.nbits + 6'h01;
         end
      end

      // A frame counts only if exactly one word arrived before the latch edge
      if (le_rise) begin
         nx.nbits = '0;
         wr = (s.nbits == FRAME_COUNT);
         addr = s.shift[ADDR_W-1:0];
      end

      if (wr) begin
         nx.regs[REG_GROUP0][RESET_BIT] = 1'b0;
         if (addr == ADDR_GROUP0 && s.shift[RESET_BIT]) begin
            nx.reset_pend = 1'b1;
         end else if (addr < ADDR_COUNT) begin
            nx.regs[addr] = {s.shift[31:ADDR_W], ADDR_PAD};
         end
         sync = (addr == ADDR_SYNTH_FB);
      end
      nx.sync_seen = sync;

      // Defaults land on the falling latch edge; rest of that frame is dropped
      if (le_fall && s.reset_pend) begin
         nx.regs = DEFAULT_REGS;
         nx.regs[REG_GROUP0][RESET_BIT] = 1'b1;
         nx.reset_pend = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////////
      // Counters run in half-period steps so odd divides keep 50% duty
      for (int g = 0; g < NUM_GROUPS; g++) begin
         r = s.regs[g];
         dv = r[DIV_MSB:DIV_LSB];
         if (dv > DIV_MAX) begin
            dv = DIV_MAX;
         end
         n2 = {dv, 1'b0};
         pd = r[PD_BIT] | dev_pd | (dv == '0);
         eff = r[DDLY_MSB:DDLY_LSB];
         if (eff < DDLY_MIN) begin
            eff = DDLY_MIN;
         end
         if (pd) begin
            nx.running[g] = 1'b0;
            nx.pos[g] = '0;
            nx.dly_cnt[g] = '0;
         end else if (sync && !group_sync_exclude[g]) begin
            nx.running[g] = 1'b0;
            nx.dly_cnt[g] = 10'(eff * DIST_DIV);
         end else if (!s.running[g]) begin
            if (s.dly_cnt[g] > DLY_ONE) begin
               nx.dly_cnt[g] = s.dly_cnt[g] - DLY_ONE;
            end else begin
               nx.running[g] = 1'b1;
               nx.pos[g] = '0;
               nx.dly_cnt[g] = '0;
            end
         end else begin
            nxt = s.pos[g] + 12'h002;
            // Wrap to zero so a smaller divide never strands the count
            if (nxt >= n2) begin
               nxt = '0;
            end
            nx.pos[g] = nxt;
         end

         // Half step moves the pattern one half period earlier at once
         a = s.pos[g] + {11'h000, r[HS_BIT]};
         if (a >= n2) begin
            a = a - n2;
         end
         b = a + 12'h001;
         if (b >= n2) begin
            b = b - n2;
         end
         if (s.running[g] && !pd) begin
            nx.phase[g] = {a < {1'b0, dv}, b < {1'b0, dv}};
         end else begin
            nx.phase[g] = 2'b00;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s <= '0;
         s.regs <= DEFAULT_REGS;
      end else begin
         s <= nx;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign group_phase = s.phase;
   assign device_power_down = s.regs[REG_POWERDOWN][POWERDOWN_BIT];
   assign soft_reset_flag = s.regs[REG_GROUP0][RESET_BIT];
   assign sync_event = s.sync_seen;

   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
      logic [10:0] div_f;
      logic on;
      assign div_f = s.regs[g][DIV_MSB:DIV_LSB];
      assign on = ~s.regs[g][PD_BIT] & ~device_power_down;
      assign group_powered[g] = on;
      if (g == SRC_GROUP_LO || g == SRC_GROUP_HI) begin : g_src
         assign group_source_select[g] = s.regs[g][SRC_BIT];
      end else begin : g_nosrc
         assign group_source_select[g] = 1'b0;
      end
      assign analog_delay_en[2*g] = on & s.regs[g][EVEN_ADLY_BIT];
      assign analog_delay_en[2*g+1] = on & s.regs[g][ODD_ADLY_BIT];
      assign analog_block_on[g] = analog_delay_en[2*g] | analog_delay_en[2*g+1];
      assign extended_power[g] = (s.regs[g][DDLY_MSB:DDLY_LSB] >= DDLY_EXT)
         | (div_f >= DIV_EXT);
   end

   ////////////////////////////////////////////////////////////////////////////////
   for (genvar o = 0; o < NUM_OUTS; o++) begin : g_out
      logic [3:0] kind;
      logic [1:0] ph;
      assign kind = s.regs[REG_TYPE0 + o / TYPES_PER_REG]
         [TYPE_LSB + TYPE_W * (o % TYPES_PER_REG) +: TYPE_W];
      assign ph = s.phase[o / 2];
      assign output_driver_type[o] = kind;
      assign output_buffer_on[o] = group_powered[o / 2] & (kind != TYPE_OFF)
         & (kind <= TYPE_SE_LL);
      // Codes above the single-ended range are treated as off
      always_comb begin
         out_p_phase[o] = 2'b00;
         out_n_phase[o] = 2'b00;
         case (kind)
            TYPE_OFF: begin
            end
            TYPE_SE_NI: begin
               out_p_phase[o] = ph;
               out_n_phase[o] = ~ph;
            end
            TYPE_SE_IN: begin
               out_p_phase[o] = ~ph;
               out_n_phase[o] = ph;
            end
            TYPE_SE_NN: begin
               out_p_phase[o] = ph;
               out_n_phase[o] = ph;
            end
            TYPE_SE_II: begin
               out_p_phase[o] = ~ph;
               out_n_phase[o] = ~ph;
            end
            TYPE_SE_LN: begin
               out_n_phase[o] = ph;
            end
            TYPE_SE_LI: begin
               out_n_phase[o] = ~ph;
            end
            TYPE_SE_NL: begin
               out_p_phase[o] = ph;
            end
            TYPE_SE_IL: begin
               out_p_phase[o] = ~ph;
            end
            TYPE_SE_LL: begin
            end
            default: begin
               if (kind <= TYPE_EMIT_MAX) begin
                  out_p_phase[o] = ph;
                  out_n_phase[o] = ~ph;
               end
            end
         endcase
         if (!output_buffer_on[o]) begin
            out_p_phase[o] = 2'b00;
            out_n_phase[o] = 2'b00;
         end
      end
   end
endmodule // cogc_device

//--- core/cogc_pkg.sv
// Constants, types and field layout shared by both ends of the clock output group control.
// Summary of operation
// - Group power-down bit stops whole group.
// - Source select only in groups three, four.
// - Two analog-delay selects; none powers block down.
// - Digital delay applied only on sync, not excluded.
// - Delay values zero to five give five.
// - Delay cycle is one distribution-path period.
// - Digital delay thirteen or more: extended power.
// - Soft reset loads defaults, ignores same write.
// - Host rewrites first register after soft reset.
// - Soft reset happens on latch-enable falling edge.
// - Soft-reset bit clears on any other write.
// - Power-down bit held until host clears it.
// - Half-step subtracts half period, immediately.
// - Divide one to 1045, fifty percent duty.
// - Divide twenty-six or more: extended power.
// - Host keeps half-step zero at divide one.
// - Feedback divider write syncs; host clears exclude (cogc_host never drives group_sync_exclude; the bench leaves it set).
// - Twelve four-bit driver fields, four per register.
// - Driver encoding: off, differential, emitter, single-ended.
// - Registers zero to five map groups in order.
package cogc_pkg;
   localparam int NUM_GROUPS = 6;
   localparam int NUM_OUTS = 12;
   localparam int NUM_REGS = 9;
   localparam int ADDR_W = 5;
   localparam int FRAME_BITS = 32;
   localparam int TYPE_W = 4;
   localparam int TYPES_PER_REG = 4;

   // Field positions within a frame word
   localparam int PD_BIT = 31;
   localparam int SRC_BIT = 30;
   localparam int ODD_ADLY_BIT = 29;
   localparam int EVEN_ADLY_BIT = 28;
   localparam int DDLY_MSB = 27;
   localparam int DDLY_LSB = 18;
   localparam int RESET_BIT = 17;
   localparam int POWERDOWN_BIT = 17;
   localparam int HS_BIT = 16;
   localparam int DIV_MSB = 15;
   localparam int DIV_LSB = 5;
   localparam int TYPE_LSB = 16;

   // Register indices and addresses
   localparam int REG_GROUP0 = 0;
   localparam int REG_POWERDOWN = 1;
   localparam int REG_TYPE0 = 6;
   localparam int SRC_GROUP_LO = 3;
   localparam int SRC_GROUP_HI = 4;
   localparam logic [4:0] ADDR_GROUP0 = 5'h00;
   localparam logic [4:0] ADDR_COUNT = 5'h09;
   localparam logic [4:0] ADDR_SYNTH_FB = 5'h1E;
   localparam logic [4:0] ADDR_PAD = 5'h00;
   localparam logic [5:0] FRAME_COUNT = 6'h20;
   localparam logic [5:0] NBITS_SAT = 6'h3F;

   // Delay and divide limits
   localparam logic [9:0] DDLY_MIN = 10'h005;
   localparam logic [9:0] DDLY_EXT = 10'h00D;
   localparam logic [9:0] DLY_ONE = 10'h001;
   localparam logic [10:0] DIV_ONE = 11'h001;
   localparam logic [10:0] DIV_EXT = 11'h01A;
   localparam logic [10:0] DIV_MAX = 11'h415;
   localparam int DIST_DIV = 1;

   // Driver type codes
   localparam logic [3:0] TYPE_OFF = 4'h0;
   localparam logic [3:0] TYPE_EMIT_MAX = 4'h5;
   localparam logic [3:0] TYPE_SE_NI = 4'h6;
   localparam logic [3:0] TYPE_SE_IN = 4'h7;
   localparam logic [3:0] TYPE_SE_NN = 4'h8;
   localparam logic [3:0] TYPE_SE_II = 4'h9;
   localparam logic [3:0] TYPE_SE_LN = 4'hA;
   localparam logic [3:0] TYPE_SE_LI = 4'hB;
   localparam logic [3:0] TYPE_SE_NL = 4'hC;
   localparam logic [3:0] TYPE_SE_IL = 4'hD;
   localparam logic [3:0] TYPE_SE_LL = 4'hE;

   // Default contents loaded at reset and soft reset
   localparam logic [31:0] GROUP_DEFAULT = 32'h0000_0020;
   localparam logic [31:0] TYPE_DEFAULT = 32'h0000_0000;
   localparam logic [NUM_REGS-1:0][31:0] DEFAULT_REGS = {{3{TYPE_DEFAULT}}, {6{GROUP_DEFAULT}}};

   // Host serial timing
   localparam int MCLK_HZ = 40_000_000;
   localparam int SCLK_HZ = 10_000_000;
   localparam int SCLK_HALF = MCLK_HZ / (2 * SCLK_HZ);
   localparam int LE_HIGH_NS = 100;
   localparam int LE_CYC = (LE_HIGH_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [3:0] HALF_LOAD = 4'(SCLK_HALF - 1);
   localparam logic [3:0] LE_LOAD = 4'(LE_CYC - 1);

   typedef enum {HS_IDLE, HS_SHIFT, HS_LATCH, HS_GAP} cogc_host_state_t;

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] data_s;
      logic [2:0] le_s;
      logic [31:0] shift;
      logic [5:0] nbits;
      logic [NUM_REGS-1:0][31:0] regs;
      logic reset_pend;
      logic sync_seen;
      logic [NUM_GROUPS-1:0] running;
      logic [NUM_GROUPS-1:0][9:0] dly_cnt;
      logic [NUM_GROUPS-1:0][11:0] pos;
      logic [NUM_GROUPS-1:0][1:0] phase;
   } cogc_dev_state_t;

   typedef struct packed {
      cogc_host_state_t state;
      logic [31:0] shift;
      logic [4:0] bitcnt;
      logic [3:0] cnt;
      logic high_half;
      logic redo;
      logic sclk;
      logic sdata;
      logic le;
   } cogc_host_state_s_t;
endpackage

//--- core/cogc_if.sv
// Three-wire programming link between the host and the clock output controller.
`timescale 1ns/1ps
interface cogc_if;
   logic sclk;
   logic sdata;
   logic le;
   modport host (output sclk, output sdata, output le);
   modport dev (input sclk, input sdata, input le);
endinterface

//--- core/cogc_host.sv
// Host end: sends register frames over the three-wire link.
`timescale 1ns/1ps
module cogc_host (
   input wire logic mclk,
   input wire logic rstn,
   cogc_if.host link,
   input wire logic wr_valid,
   input wire logic [cogc_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [26:0] wr_data,
   output logic wr_ready
);
   import cogc_pkg::*;

   cogc_host_state_s_t s;
   cogc_host_state_s_t nx;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0] frame;
      logic tick;
      frame = {wr_data, wr_addr};
      tick = (s.cnt == 4'h0);
      nx = s;
      if (!tick) begin
         nx.cnt = s.cnt - 4'h1;
      end
      // Divide-by-one with half step is illegal, so strip it
      if (wr_addr < 5'(REG_TYPE0) && frame[DIV_MSB:DIV_LSB] == DIV_ONE) begin
         frame[HS_BIT] = 1'b0;
      end
      case (s.state)
         HS_IDLE: begin
            if (wr_valid) begin
               nx.state = HS_SHIFT;
               nx.shift = frame;
               nx.sdata = frame[31];
               nx.bitcnt = '0;
               nx.high_half = 1'b0;
               nx.cnt = HALF_LOAD;
               // Reset frame drops its other fields; a default frame follows
               nx.redo = (wr_addr == ADDR_GROUP0) && frame[RESET_BIT];
            end
         end
         HS_SHIFT: begin
            if (tick) begin
               nx.cnt = HALF_LOAD;
               if (!s.high_half) begin
                  nx.sclk = 1'b1;
                  nx.high_half = 1'b1;
               end else begin
                  nx.sclk = 1'b0;
                  nx.high_half = 1'b0;
                  nx.shift = {s.shift[30:0], 1'b0};
                  nx.sdata = s.shift[30];
                  nx.bitcnt = s.bitcnt + 5'h01;
                  if (s.bitcnt == 5'(FRAME_BITS - 1)) begin
                     nx.state = HS_LATCH;
                     nx.le = 1'b1;
                     nx.sdata = 1'b0;
                     nx.cnt = LE_LOAD;
                  end
               end
            end
         end
         HS_LATCH: begin
            if (tick) begin
               nx.le = 1'b0;
               nx.state = HS_GAP;
               nx.cnt = LE_LOAD;
            end
         end
         HS_GAP: begin
            if (tick) begin
               if (s.redo) begin
                  nx.redo = 1'b0;
                  nx.state = HS_SHIFT;
                  // Defaults with the reset bit low, never a reserved divide of zero
                  nx.shift = {GROUP_DEFAULT[FRAME_BITS-1:ADDR_W], ADDR_GROUP0};
                  nx.sdata = GROUP_DEFAULT[FRAME_BITS-1];
                  nx.bitcnt = '0;
                  nx.high_half = 1'b0;
                  nx.cnt = HALF_LOAD;
               end else begin
                  nx.state = HS_IDLE;
               end
            end
         end
         default: begin
            nx.state = HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s <= '0;
         s.state <= HS_IDLE;
      end else begin
         s <= nx;
      end
   end

   assign wr_ready = (s.state == HS_IDLE);
   assign link.sclk = s.sclk;
   assign link.sdata = s.sdata;
   assign link.le = s.le;
   // Power-down release and feedback-divider syncs are ordinary frames here
endmodule // cogc_host

//--- core/cogc_note_unused.sv
// Holds no logic; each end of the link lives in its own file.
`timescale 1ns/1ps

//--- verification/cogc_monitor.sv
// Wire-level checker for the three-wire link between host and device ends.
`timescale 1ns/1ps
module cogc_monitor (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic le
);
   logic sclk_q;
   logic [5:0] nbits;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////////
   // Rising serial-clock edges since the last latch, cleared while latch is high
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         nbits <= 6'h00;
      end else begin
         sclk_q <= sclk;
         if (le) begin
            nbits <= 6'h00;
         end else if (sclk && !sclk_q) begin
            nbits <= nbits + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_frame_bit_count: assert property ($rose(le) |-> nbits == 6'h20)
      else $error("frame latched with wrong bit count");
   a_clock_idle_latch: assert property (le |-> !sclk)
      else $error("serial clock high while latch high");
   a_latch_width: assert property ($rose(le) |-> le [*4] ##1 !le)
      else $error("latch pulse not four cycles wide");
   a_clock_high_width: assert property ($rose(sclk) |-> sclk [*2] ##1 !sclk)
      else $error("serial clock high phase wrong");
   a_clock_low_width: assert property ($fell(sclk) |-> !sclk [*2])
      else $error("serial clock low phase too short");
   a_data_setup: assert property ($rose(sclk) |-> sdata == $past(sdata, 2))
      else $error("serial data changed just before clock rise");
   a_data_hold: assert property (sclk |-> $stable(sdata))
      else $error("serial data changed while clock high");
   a_gap_after_latch: assert property ($fell(le) |-> !sclk [*4])
      else $error("serial clock restarted too soon after latch");
endmodule // cogc_monitor

//--- verification/testbench.sv
// Self-checking bench: host end drives device end over the link, device outputs compared.
`timescale 1ns/1ps
module testbench;
   import cogc_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic wr_valid = 1'b0;
   logic [4:0] wr_addr = 5'h00;
   logic [26:0] wr_data = 27'h0000000;
   logic wr_ready;
   logic [5:0] group_sync_exclude = 6'h00;
   logic [5:0][1:0] group_phase;
   logic [5:0] group_powered, group_source_select, analog_block_on, extended_power;
   logic [11:0] analog_delay_en, output_buffer_on;
   logic [11:0][3:0] output_driver_type;
   logic [11:0][1:0] out_p_phase, out_n_phase;
   logic device_power_down, soft_reset_flag, sync_event;
   int num_errors = 0;
   int comparisons = 0;
   int ts, cnt, n, i;
   int tf[3];
   bit seen_low[3];
   bit split;
   logic [31:0] gw[6] = '{32'h5000_0040, 32'h2030_0320, 32'h8000_0060, 32'h7000_0340,
      32'h4034_0080, 32'h4000_00A0};

   cogc_if link ();
   cogc_host i_cogc_host (.mclk(mclk), .rstn(rstn), .link(link), .wr_valid(wr_valid),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));
   cogc_device i_cogc_device (.mclk(mclk), .rstn(rstn), .link(link),
      .group_sync_exclude(group_sync_exclude), .group_phase(group_phase),
      .group_powered(group_powered), .group_source_select(group_source_select),
      .analog_block_on(analog_block_on), .analog_delay_en(analog_delay_en),
      .extended_power(extended_power), .output_driver_type(output_driver_type),
      .output_buffer_on(output_buffer_on), .out_p_phase(out_p_phase),
      .out_n_phase(out_n_phase), .device_power_down(device_power_down),
      .soft_reset_flag(soft_reset_flag), .sync_event(sync_event));
   cogc_monitor i_cogc_monitor (.mclk(mclk), .rstn(rstn), .sclk(link.sclk),
      .sdata(link.sdata), .le(link.le));

   always #12.5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Request is taken at the first edge since the host is idle on entry
   task automatic send(input logic [4:0] a, input logic [31:0] w);
      @(posedge mclk);
      wr_valid <= 1'b1;
      wr_addr <= a;
      wr_data <= w[31:5];
      @(posedge mclk);
      wr_valid <= 1'b0;
      @(posedge mclk);
   endtask

   // Bounded waits, sampled mid-cycle so edge updates have landed
   task automatic wait_for(input string name, ref logic sig, input logic lvl);
      int k;
      k = 0;
      while (sig !== lvl && k < 400) begin
         @(negedge mclk);
         k++;
      end
      check(name, 48'(k < 400), 48'h1);
   endtask

   task automatic write(input logic [4:0] a, input logic [31:0] w);
      send(a, w);
      wait_for("ready", wr_ready, 1'b1);
   endtask

   task automatic halves(input int g, input int cycles);
      cnt = 0;
      split = 1'b1;
      repeat (cycles) begin
         @(negedge mclk);
         cnt += int'(group_phase[g][1]) + int'(group_phase[g][0]);
         if (group_phase[g][1] === group_phase[g][0]) split = 1'b0;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(negedge mclk);
      check("types", output_driver_type, 48'h0);
      check("powered", group_powered, 48'h3F);
      for (i = 0; i < 6; i++) write(5'(i), gw[i]);
      check("powered", group_powered, 48'h3B);
      check("source", group_source_select, 48'h18);
      check("adly_block", analog_block_on, 48'h0B);
      check("adly_en", analog_delay_en, 48'h0C9);
      check("ext_power", extended_power, 48'h18);
      write(5'h06, 32'h4321_0000);
      write(5'h07, 32'h8765_0000);
      write(5'h08, 32'h0EA9_0000);
      check("types", output_driver_type, 48'h0EA9_8765_4321);
      for (i = 0; i < 12; i++) begin
         n = int'(4'(48'h0EA9_8765_4321 >> (4 * i)));
         check("buffer", output_buffer_on[i], 48'(n != 0 && i / 2 != 2));
      end
      check("low_low", {out_p_phase[10], out_n_phase[10], out_p_phase[9]}, 48'h0);
      check("p_n_0", {out_p_phase[0], out_n_phase[0]},
         {group_phase[0], ~group_phase[0]});
      check("p_n_6", {out_p_phase[6], out_n_phase[6]},
         {~group_phase[3], group_phase[3]});
      write(5'h09, 32'hFFFF_FFE0);
      check("types", output_driver_type, 48'h0EA9_8765_4321);
      check("powered", group_powered, 48'h3B);
      write(5'h01, 32'h0002_0020);
      check("pdown", device_power_down, 48'h1);
      check("pd_groups", group_powered, 48'h00);
      write(5'h01, 32'h0000_0020);
      check("pdown", device_power_down, 48'h0);
      // Soft reset with pd bit set too: that bit must be dropped
      send(5'h00, 32'h8002_0000);
      wait_for("le_high", link.le, 1'b1);
      check("types", output_driver_type, 48'h0EA9_8765_4321);
      wait_for("le_low", link.le, 1'b0);
      repeat (5) @(negedge mclk);
      check("soft_flag", soft_reset_flag, 48'h1);
      check("types", output_driver_type, 48'h0);
      check("powered", group_powered, 48'h3F);
      wait_for("ready", wr_ready, 1'b1);
      check("soft_flag", soft_reset_flag, 48'h0);
      // Sync: delays 0, 5, 8 at divide 1; group 3 excluded
      @(posedge mclk);
      group_sync_exclude <= 6'h08;
      write(5'h00, 32'h0000_0020);
      write(5'h01, 32'h0014_0020);
      write(5'h02, 32'h0020_0020);
      write(5'h03, 32'h0020_0020);
      check("no_sync_yet", group_phase[2], 48'h2);
      send(ADDR_SYNTH_FB, 32'h0);
      ts = -1;
      tf = '{-1, -1, -1};
      seen_low = '{0, 0, 0};
      for (n = 0; n < 200; n++) begin
         @(negedge mclk);
         if (sync_event === 1'b1) ts = n;
         if (ts >= 0 && n > ts) begin
            check("excluded", group_phase[3], 48'h2);
            for (i = 0; i < 3; i++) begin
               if (group_phase[i][1] === 1'b0) seen_low[i] = 1'b1;
               else if (seen_low[i] && tf[i] < 0) tf[i] = n;
            end
         end
      end
      wait_for("ready", wr_ready, 1'b1);
      check("synced", 48'(ts >= 0 && tf[0] > ts), 48'h1);
      check("dly5_eq_dly0", 48'(tf[1] - tf[0]), 48'h0);
      check("dly8_minus_dly0", 48'(tf[2] - tf[0]), 48'h3);
      write(5'h04, 32'h0000_0060);
      halves(4, 6);
      check("odd_duty", 48'(cnt), 48'h6);
      write(5'h04, 32'h0001_0040);
      halves(4, 4);
      check("hs_duty", 48'(cnt), 48'h4);
      check("hs_shift", 48'(split), 48'h1);
      tally_and_finish();
   end

   initial begin
      #(20000 * 25);
      num_errors++;
      tally_and_finish();
   end
endmodule // testbench
